//--- core/cis_pkg.sv
// package: constants, register map and types of the core interrupt sequencer
package cis_pkg;

  // ==========================================================================
  // clocking
  // ==========================================================================
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // one instruction cycle is four q phases of aclk
  localparam int unsigned Q_PER_CYCLE = 4;

  // ==========================================================================
  // register map, byte addresses
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PFLAG_A = 8'h04;
  localparam logic [7:0] OFS_PFLAG_B = 8'h08;
  localparam logic [7:0] OFS_PEN_A = 8'h0C;
  localparam logic [7:0] OFS_PEN_B = 8'h10;
  localparam logic [7:0] OFS_OPTION = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;

  // irq_control_register fields
  localparam int unsigned CTL_GIE = 7;
  localparam int unsigned CTL_PERIPHERAL_GROUP_IRQ_ENABLE = 6;
  localparam int unsigned CTL_TMR0E = 5;
  localparam int unsigned CTL_INTE = 4;
  localparam int unsigned CTL_IOCE = 3;
  localparam int unsigned CTL_TMR0F = 2;
  localparam int unsigned CTL_EXT_PIN_IRQ_FLAG = 1;
  localparam int unsigned CTL_IOCF = 0;
  // option register field
  localparam int unsigned OPT_EDGE = 0;

  // reset values
  localparam logic [7:0] RST_PFLAG = 8'h00;
  localparam logic [7:0] RST_PEN = 8'h00;
  localparam logic RST_EDGE_SEL = 1'b1;

  // ==========================================================================
  // core side
  // ==========================================================================
  localparam int unsigned PC_W = 15;
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;
  // context: w[7:0] status[15:8] bsr[20:16] fsr0[36:21] fsr1[52:37] pclath[59:53]
  localparam int unsigned CTX_W = 60;
  localparam int unsigned STATUS_LSB = 8;
  // timeout and power-down bits stay live across a return
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h18;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CIS_RUN = 3'h0,
    CIS_FLUSH = 3'h1,
    CIS_PUSH = 3'h2,
    CIS_SLEEP = 3'h3,
    CIS_WAKE = 3'h4
  } cis_state_e;

endpackage

//--- core/cis_cycle_div.sv
// instruction-cycle enable divider for the interrupt sequencer
module cis_cycle_div
  import cis_pkg::*;
#(
  parameter int unsigned Q_PER = cis_pkg::Q_PER_CYCLE
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic cyc_en
);

  typedef struct packed {
    logic [7:0] cnt;
    logic en;
  } cis_div_s;

  cis_div_s q, n;

  always_comb begin
    n = q;
    n.en = 1'b0;
    if (q.cnt == 8'(Q_PER - 1)) begin
      n.cnt = 8'h00;
      n.en = 1'b1;
    end else begin
      n.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign cyc_en = q.en;

endmodule

//--- core/cis_edge_detect.sv
// synchroniser and selectable edge detector for the external interrupt pin
module cis_edge_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_async,
  input wire logic rising_sel,
  output logic edge_pulse
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [2:0] arm;
    logic pulse;
  } cis_edge_s;

  cis_edge_s q, n;

  always_comb begin
    n = q;
    n.s1 = pin_async;
    n.s2 = q.s1;
    n.prev = q.s2;
    // stages refill after reset: a pin already high would look like an edge
    n.arm = {q.arm[1:0], 1'b1};
    // edge polarity chosen by the edge select bit [R15]
    n.pulse = q.arm[2] & (rising_sel ? (q.s2 & ~q.prev) : (~q.s2 & q.prev)); // [R14]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign edge_pulse = q.pulse;

endmodule

//--- core/cis_interrupt_sequencer.sv
// core interrupt sequencer: flags, enables, entry, return and sleep wake
//
// Function
// (R01) any reset leaves every interrupt disabled
// (R02) redirect needs own, group and global enables; here group enable gates only peripheral flags
// (R03) flags set regardless of any enable
// (R04) entry: flush, clear global, push, save, vector
// (R05) firmware polls and clears flags before returning
// (R06) flags still set while global enable cleared
// (R07) return pops, restores context, sets global enable
// (R08) pending flag serviced once global enable returns
// (R09) synchronous latency three to four cycles
// (R10) asynchronous latency three to five cycles
// (R11) clockless enabled sources alone wake from sleep
// (R12) wake vectors only when global enable set
// (R13) instruction after sleep runs before vectoring
// (R14) external pin is edge triggered, own enable
// (R15) edge select: one rising, zero falling
// (R16) valid pin edge sets pin flag
// (R17) pin flag may set in any phase
// (R18) context covers w, status, bsr, fsr, pclath
// (R19) request is or of gated flag terms
//
// Design decisions made here: the address map and register access over AXI4-Lite.
module cis_interrupt_sequencer
  import cis_pkg::*;
#(
  parameter logic [7:0] WAKE_MASK_A = 8'hFF,
  parameter logic [7:0] WAKE_MASK_B = 8'hFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cis_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cis_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tmr0_evt,
  input wire logic ioc_flag_in,
  input wire logic [7:0] periph_evt_a,
  input wire logic [7:0] periph_evt_b,
  input wire logic ext_pin,
  input wire logic core_return_from_interrupt,
  input wire logic core_sleep,
  input wire logic [cis_pkg::PC_W-1:0] core_pc,
  input wire logic [cis_pkg::CTX_W-1:0] ctx_in,
  output logic irq,
  output logic flush_prefetch,
  output logic push_pc,
  output logic [cis_pkg::PC_W-1:0] push_pc_value,
  output logic load_vector,
  output logic [cis_pkg::PC_W-1:0] vector_pc,
  output logic pop_pc,
  output logic restore_ctx,
  output logic [cis_pkg::CTX_W-1:0] ctx_out,
  output logic sleeping,
  output logic wake
);

  import cis_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    cis_state_e state;
    logic global_irq_enable;
    logic peripheral_group_irq_enable;
    logic tmr0e;
    logic inte;
    logic ioce;
    logic tmr0f;
    logic ext_pin_irq_flag;
    logic [7:0] peripheral_flag_register_a;
    logic [7:0] peripheral_flag_register_b;
    logic [7:0] peripheral_enable_register_a;
    logic [7:0] peripheral_enable_register_b;
    logic ext_edge_select;
    logic irq;
    logic flush;
    logic push;
    logic load_vec;
    logic pop;
    logic restore;
    logic wake;
    logic sleeping;
    logic [PC_W-1:0] push_pc_value;
    logic [PC_W-1:0] vector_pc;
    logic [CTX_W-1:0] shadow;
    logic [CTX_W-1:0] ctx_out;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } cis_regs_s;

  localparam cis_regs_s RST_S = '{
    state: CIS_RUN,
    ext_edge_select: RST_EDGE_SEL,
    peripheral_flag_register_a: RST_PFLAG,
    peripheral_flag_register_b: RST_PFLAG,
    peripheral_enable_register_a: RST_PEN,
    peripheral_enable_register_b: RST_PEN,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };

  cis_regs_s q, n;
  logic cyc_en;
  logic ext_edge;
  logic do_wr;
  logic [7:0] w1c_ctl;
  logic [7:0] w1c_a;
  logic [7:0] w1c_b;
  logic wake_req;

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == OFS_CTRL) || (a == OFS_PFLAG_A) || (a == OFS_PFLAG_B) ||
                  (a == OFS_PEN_A) || (a == OFS_PEN_B) || (a == OFS_OPTION) || (a == OFS_STATE);
  endfunction

  // gated flag terms; wmask_a/b limit peripherals when waking
  function automatic logic flag_terms(input cis_regs_s r, input logic ioc, input logic [7:0] wmask_a,
                                      input logic [7:0] wmask_b, input logic use_tmr0);
    logic periph;
    periph = |(r.peripheral_flag_register_a & r.peripheral_enable_register_a & wmask_a) |
             |(r.peripheral_flag_register_b & r.peripheral_enable_register_b & wmask_b);
    flag_terms = (use_tmr0 & r.tmr0e & r.tmr0f) | (r.inte & r.ext_pin_irq_flag) | (r.ioce & ioc) |
                 (r.peripheral_group_irq_enable & periph); // [R02] [R19]
  endfunction

  // status keeps its live timeout and power-down bits on return
  function automatic logic [CTX_W-1:0] ctx_merge(input logic [CTX_W-1:0] saved, input logic [CTX_W-1:0] live);
    logic [CTX_W-1:0] m;
    m = saved;
    m[STATUS_LSB+:8] = (saved[STATUS_LSB+:8] & ~STATUS_KEEP_MASK) | (live[STATUS_LSB+:8] & STATUS_KEEP_MASK);
    ctx_merge = m; // [R18]
  endfunction

  function automatic logic [7:0] rd_reg(input cis_regs_s r, input logic [ADDR_W-1:0] a, input logic ioc);
    case (a)
      OFS_CTRL: rd_reg = {r.global_irq_enable, r.peripheral_group_irq_enable, r.tmr0e, r.inte, r.ioce,
                          r.tmr0f, r.ext_pin_irq_flag, ioc};
      OFS_PFLAG_A: rd_reg = r.peripheral_flag_register_a;
      OFS_PFLAG_B: rd_reg = r.peripheral_flag_register_b;
      OFS_PEN_A: rd_reg = r.peripheral_enable_register_a;
      OFS_PEN_B: rd_reg = r.peripheral_enable_register_b;
      OFS_OPTION: rd_reg = {7'h00, r.ext_edge_select};
      OFS_STATE: rd_reg = {4'h0, r.sleeping, r.state};
      default: rd_reg = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // leaves
  // ==========================================================================
  cis_cycle_div #(.Q_PER(Q_PER_CYCLE)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .cyc_en(cyc_en)
  );

  // async pin: sync adds up to one more cycle of latency [R10]
  cis_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async(ext_pin),
    .rising_sel(q.ext_edge_select),
    .edge_pulse(ext_edge)
  );

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    n = q;
    w1c_ctl = 8'h00;
    w1c_a = 8'h00;
    w1c_b = 8'h00;
    n.flush = 1'b0;
    n.push = 1'b0;
    n.load_vec = 1'b0;
    n.pop = 1'b0;
    n.restore = 1'b0;
    n.wake = 1'b0;

    // axi write: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    do_wr = n.aw_got && n.w_got && !q.bvalid;
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_mapped(n.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (n.wstrb0) begin
        case (n.awaddr)
          OFS_CTRL: begin
            n.global_irq_enable = n.wdata[CTL_GIE];
            n.peripheral_group_irq_enable = n.wdata[CTL_PERIPHERAL_GROUP_IRQ_ENABLE];
            n.tmr0e = n.wdata[CTL_TMR0E];
            n.inte = n.wdata[CTL_INTE];
            n.ioce = n.wdata[CTL_IOCE];
            w1c_ctl = n.wdata;
          end
          OFS_PFLAG_A: w1c_a = n.wdata;
          OFS_PFLAG_B: w1c_b = n.wdata;
          OFS_PEN_A: n.peripheral_enable_register_a = n.wdata;
          OFS_PEN_B: n.peripheral_enable_register_b = n.wdata;
          OFS_OPTION: n.ext_edge_select = n.wdata[OPT_EDGE];
          default: n.bvalid = 1'b1;
        endcase
      end
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // axi read: one cycle to rvalid, held until rready
    if (s_axi_arvalid && q.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rdata = rd_reg(q, s_axi_araddr, ioc_flag_in);
      n.rresp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // flags: events set regardless of enables, and set wins over clear [R03] [R06]
    n.tmr0f = (q.tmr0f & ~w1c_ctl[CTL_TMR0F]) | tmr0_evt;
    n.ext_pin_irq_flag = (q.ext_pin_irq_flag & ~w1c_ctl[CTL_EXT_PIN_IRQ_FLAG]) | ext_edge; // [R16] [R17]
    n.peripheral_flag_register_a = (q.peripheral_flag_register_a & ~w1c_a) | periph_evt_a;
    n.peripheral_flag_register_b = (q.peripheral_flag_register_b & ~w1c_b) | periph_evt_b;

    // only clockless sources with enables set may wake [R11]
    wake_req = flag_terms(q, ioc_flag_in, WAKE_MASK_A, WAKE_MASK_B, 1'b0);

    case (q.state)
      CIS_RUN: begin
        if (core_return_from_interrupt) begin
          n.pop = 1'b1;
          n.restore = 1'b1;
          n.ctx_out = ctx_merge(q.shadow, ctx_in);
          n.global_irq_enable = 1'b1; // [R07]
        end else if (core_sleep) begin
          n.state = CIS_SLEEP;
          n.sleeping = 1'b1;
        end else if (cyc_en && q.irq) begin
          // held flag is taken as soon as the enable returns [R08]
          n.state = CIS_FLUSH;
          n.flush = 1'b1; // [R04] [R09]
        end
      end
      CIS_FLUSH: begin
        if (cyc_en) begin
          n.state = CIS_PUSH;
          n.push = 1'b1;
          n.push_pc_value = core_pc;
          n.shadow = ctx_in; // [R18]
          n.global_irq_enable = 1'b0; // [R04]
        end
      end
      CIS_PUSH: begin
        if (cyc_en) begin
          n.state = CIS_RUN;
          n.load_vec = 1'b1;
          n.vector_pc = VECTOR_ADDR; // [R04]
        end
      end
      CIS_SLEEP: begin
        if (wake_req) begin
          n.state = CIS_WAKE;
          n.sleeping = 1'b0;
          n.wake = 1'b1;
        end
      end
      CIS_WAKE: begin
        // hold until the next cycle enable for the instruction after sleep; vector only via run [R12] [R13]
        if (cyc_en) begin
          n.state = CIS_RUN;
        end
      end
      default: n.state = CIS_RUN;
    endcase

    n.irq = n.global_irq_enable & flag_terms(n, ioc_flag_in, 8'hFF, 8'hFF, 1'b1); // [R19] [R02]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_S; // [R01]
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign irq = q.irq;
  assign flush_prefetch = q.flush;
  assign push_pc = q.push;
  assign push_pc_value = q.push_pc_value;
  assign load_vector = q.load_vec;
  assign vector_pc = q.vector_pc;
  assign pop_pc = q.pop;
  assign restore_ctx = q.restore;
  assign ctx_out = q.ctx_out;
  assign sleeping = q.sleeping;
  assign wake = q.wake;

  // ==========================================================================
  // assertions
  // ==========================================================================
  reset_disable_a: assert property (@(posedge aclk) !aresetn |=> !q.global_irq_enable && !irq) // [R01]
    else $error("reset left interrupts enabled");

  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
    periph_evt_a[0] |=> q.peripheral_flag_register_a[0])
    else $error("peripheral event did not set its flag");

  entry_order_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
    flush_prefetch |-> ##[1:4] (push_pc && !q.global_irq_enable) ##[1:4] (load_vector && vector_pc == VECTOR_ADDR))
    else $error("entry sequence out of order");

  no_redirect_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
    (q.state == CIS_RUN && !q.global_irq_enable) |=> !flush_prefetch)
    else $error("redirect with global enable clear");

  return_from_interrupt_gie_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
    (core_return_from_interrupt && q.state == CIS_RUN) |=> (q.global_irq_enable && pop_pc && restore_ctx))
    else $error("return did not restore and enable");

  sync_latency_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
    (q.state == CIS_RUN && q.irq && !core_return_from_interrupt && !core_sleep) |-> ##[1:13] load_vector)
    else $error("vector not reached in time");

  edge_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    ext_edge |=> q.ext_pin_irq_flag)
    else $error("pin edge did not set pin flag");

  wake_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    wake |-> !flush_prefetch [*4])
    else $error("vectored before instruction after sleep");

  status_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    restore_ctx |-> ((ctx_out[STATUS_LSB+:8] & STATUS_KEEP_MASK) == ($past(ctx_in[STATUS_LSB+:8]) & STATUS_KEEP_MASK)))
    else $error("timeout or power-down bits restored from shadow");

endmodule

//--- bench/cis_core_model.sv
// behavioural processor core facing the interrupt sequencer
module cis_core_model
  import cis_pkg::*;
#(
  parameter logic [59:0] CTX_INIT = 60'h0123456789ABCDE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push_pc,
  input wire logic [cis_pkg::PC_W-1:0] push_pc_value,
  input wire logic load_vector,
  input wire logic [cis_pkg::PC_W-1:0] vector_pc,
  input wire logic pop_pc,
  input wire logic restore_ctx,
  input wire logic [cis_pkg::CTX_W-1:0] ctx_out,
  output logic [cis_pkg::PC_W-1:0] core_pc,
  output logic [cis_pkg::CTX_W-1:0] ctx_in
);
  logic [PC_W-1:0] stk_q[$];
  logic [1:0] ph_q;

  // ==========================
  // fetch, stack and context
  // ==========================
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_pc <= '0;
      ctx_in <= CTX_INIT;
      ph_q <= 2'h0;
      stk_q.delete();
    end else begin
      ph_q <= ph_q + 2'h1;
      if (push_pc) stk_q.push_back(push_pc_value);
      if (load_vector) begin
        core_pc <= vector_pc;
        // routine scribbles on every live register, so a lost restore shows
        ctx_in <= {ctx_in[58:0], ~ctx_in[59]} ^ 60'h5A5A5A5A5A5A5A5;
      end else if (pop_pc && stk_q.size() > 0) begin
        core_pc <= stk_q.pop_back();
      end else if (ph_q == 2'h3) begin
        core_pc <= core_pc + 15'h1;
      end
      if (restore_ctx) ctx_in <= ctx_out;
    end
  end
endmodule

//--- bench/tb.sv
// self-checking bench for the core interrupt sequencer
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cis_pkg::*;

  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, periph_evt_a, periph_evt_b, pa, pb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tmr0_evt, ioc_flag_in, ext_pin, core_return_from_interrupt, core_sleep, irq, flush_prefetch;
  logic push_pc, load_vector, pop_pc, restore_ctx, sleeping, wake;
  logic [PC_W-1:0] core_pc, push_pc_value, vector_pc;
  logic [CTX_W-1:0] ctx_in, ctx_out, saved, live;
  logic [33:0] wq[$], rq[$];
  int bad_count = 0;
  int num_checks = 0;
  int nvec = 0;
  int nwake = 0;
  int n, v0;

  always #12.5 aclk = ~aclk;

  cis_interrupt_sequencer uut (.*);
  cis_core_model core (.*);

  // ==========================
  // helpers
  // ==========================
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(int c);
    repeat (c) @(posedge aclk);
  endtask

  task automatic rst();
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] r = RESP_OKAY);
    wq.push_back(34'(r));
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] d, logic [1:0] r = RESP_OKAY);
    rq.push_back({r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask

  task automatic tick_tmr0();
    tmr0_evt <= 1'b1;
    @(posedge aclk);
    tmr0_evt <= 1'b0;
  endtask

  task automatic pin(logic v);
    ext_pin <= v;
    cyc(8);
  endtask

  // waits for the vector load, noting the entry steps on the way
  task automatic go(output int c);
    int f = -1;
    int p = -1;
    c = 0;
    do begin
      @(posedge aclk);
      c++;
      if (flush_prefetch === 1'b1) f = c;
      if (push_pc === 1'b1) begin
        p = c;
        saved = ctx_in;
      end
    end while (load_vector !== 1'b1 && c < 100);
    chk("entry_order", 1, f > 0 && f < p && p < c);
    chk("vector_pc", 64'(VECTOR_ADDR), 64'(vector_pc));
  endtask

  task automatic ret();
    logic [CTX_W-1:0] keep;
    keep = CTX_W'(STATUS_KEEP_MASK) << STATUS_LSB;
    live = ctx_in;
    core_return_from_interrupt <= 1'b1;
    @(posedge aclk);
    core_return_from_interrupt <= 1'b0;
    @(posedge aclk);
    chk("pop_restore", 1, pop_pc && restore_ctx);
    chk("ctx_out", 64'((saved & ~keep) | (live & keep)), 64'(ctx_out));
  endtask

  task automatic slp();
    core_sleep <= 1'b1;
    @(posedge aclk);
    core_sleep <= 1'b0;
    @(posedge aclk);
    chk("sleeping", 1, sleeping);
  endtask

  // ==========================
  // response scoreboard
  // ==========================
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk("bresp", 64'(wq.pop_front()), 64'(s_axi_bresp));
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk("rdata", 64'(rq.pop_front()), 64'({s_axi_rresp, s_axi_rdata}));
    if (load_vector === 1'b1) nvec++;
    if (wake === 1'b1) nwake++;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    wrap_up();
  end

  // ==========================
  // scenarios
  // ==========================
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tmr0_evt, ioc_flag_in} = '0;
    {ext_pin, core_return_from_interrupt, core_sleep} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    periph_evt_a = '0;
    periph_evt_b = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    aresetn = 1'b0;
    void'($urandom(54994));
    rst();
    rd(OFS_CTRL, 8'h00);
    rd(OFS_OPTION, 8'h01);
    rd(8'h1C, 8'h00, RESP_SLVERR);
    wr(8'h1C, 8'hFF, RESP_SLVERR);
    pa = 8'($urandom_range(1, 255));
    pb = 8'($urandom_range(1, 255));
    periph_evt_a <= pa;
    periph_evt_b <= pb;
    tick_tmr0();
    periph_evt_a <= 8'h00;
    periph_evt_b <= 8'h00;
    rd(OFS_PFLAG_A, pa);
    rd(OFS_PFLAG_B, pb);
    rd(OFS_CTRL, 8'h04);
    wr(OFS_PEN_A, pa);
    wr(OFS_CTRL, 8'h84);
    cyc(12);
    chk("irq_nogroup", 0, irq);
    wr(OFS_CTRL, 8'hC0);
    go(n);
    rd(OFS_CTRL, 8'h40);
    tick_tmr0();
    cyc(12);
    rd(OFS_CTRL, 8'h44);
    chk("irq_in_routine", 0, irq);
    wr(OFS_PFLAG_A, pa);
    wr(OFS_CTRL, 8'h60);
    ret();
    go(n);
    wr(OFS_CTRL, 8'h24);
    ret();
    tick_tmr0();
    go(n);
    chk("sync_latency", 1, n <= 4 * Q_PER_CYCLE);
    wr(OFS_CTRL, 8'h04);
    ret();
    wr(OFS_CTRL, 8'h10);
    // wrong edge first, then the selected one, for both settings
    for (int s = 0; s < 2; s++) begin
      pin(s[0]);
      wr(OFS_OPTION, {7'h0, s[0]});
      pin(!s[0]);
      rd(OFS_CTRL, 8'h10);
      pin(s[0]);
      rd(OFS_CTRL, 8'h12);
      wr(OFS_CTRL, 8'h12);
    end
    v0 = nvec;
    slp();
    pin(1'b0);
    pin(1'b1);
    chk("wake_count", 1, nwake);
    cyc(20);
    chk("no_vector", v0, nvec);
    chk("awake", 0, sleeping);
    wr(OFS_CTRL, 8'h90);
    go(n);
    wr(OFS_CTRL, 8'h12);
    ret();
    slp();
    pin(1'b0);
    ext_pin <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    go(n);
    chk("wake_gap", 1, n > Q_PER_CYCLE);
    wr(OFS_CTRL, 8'h12);
    ret();
    pin(1'b0);
    ext_pin <= 1'b1;
    go(n);
    chk("async_latency", 1, n <= 5 * Q_PER_CYCLE);
    rst();
    rd(OFS_CTRL, 8'h00);
    chk("irq_reset", 0, irq);
    ioc_flag_in <= 1'b1;
    cyc(8);
    rd(OFS_CTRL, 8'h01);
    wrap_up();
  end
endmodule
